//--- logic/overrange_detector.sv
// Over-range detector with per-channel held flag outputs
// Notes on behaviour
// (RULE_01) Capture one signed sample per rising clock
// (RULE_02) Samples are two's complement, -2048 to +2047
// (RULE_03) Compare upper eight bits of magnitude
// (RULE_04) Most negative code saturates to 2047
// (RULE_05) Drop three magnitude LSBs before comparing
// (RULE_06) One threshold serves every channel
// (RULE_07) Detection works only while enable is one
// (RULE_08) Flag set when value reaches threshold
// (RULE_09) One flag pin per present channel
// (RULE_10) Hold 8 to 1024 cycles after event
// (RULE_11) New event restarts hold; reset clears all
//
// Pipeline per channel:
//   edge E    the sample is captured into sample_reg
//   edge E+1  the saturated magnitude's top bits land in cmp_reg
//   edge E+2  the flag rises if the comparison value met the threshold
// The flag then stands for the selected hold length, counted from the
// cycle in which it rose, and every further event reloads the count.
// The threshold and the enable are read without a register, so a change
// of either acts on the comparison value that is already in cmp_reg.
// Dropping the enable clears flags and counters at the next edge; a hold
// is never resumed when the enable returns.
`timescale 1ns/1ps
`default_nettype none
module overrange_detector
  import ovr_detect_pkg::*;
#(
  parameter int NUM_CHAN = 4
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [SAMPLE_W-1:0] i_sample_chan_a,
  input wire logic [SAMPLE_W-1:0] i_sample_chan_b,
  input wire logic [SAMPLE_W-1:0] i_sample_chan_c,
  input wire logic [SAMPLE_W-1:0] i_sample_chan_d,
  input wire logic [CMP_W-1:0] i_overrange_threshold,
  input wire logic i_overrange_detect_enable,
  input wire logic [SEL_W-1:0] i_flag_hold_length_select,
  output logic o_flag_out_chan_a,
  output logic o_flag_out_chan_b,
  output logic o_flag_out_chan_c,
  output logic o_flag_out_chan_d
);

  // Only the quad, dual and single variants exist
  if (NUM_CHAN != 1 && NUM_CHAN != 2 && NUM_CHAN != MAX_CHAN) begin : g_bad_chan
    $error("NUM_CHAN must be 1, 2 or 4");
  end

  // Magnitude of a signed sample, saturating the most negative code
  function automatic logic [MAG_W-1:0] mag_fn(input logic [SAMPLE_W-1:0] s);
    logic [SAMPLE_W-1:0] neg;
    neg = SAMPLE_W'(~s + 1'b1);
    if (s == MIN_CODE) begin
      mag_fn = MAX_MAG;
    end else if (s[SAMPLE_W-1]) begin
      mag_fn = neg[MAG_W-1:0];
    end else begin
      mag_fn = s[MAG_W-1:0];
    end
  endfunction

  // Hold length in cycles for a select value: 8 shifted left by select
  function automatic logic [HOLD_W-1:0] hold_len_fn(input logic [SEL_W-1:0] sel);
    hold_len_fn = HOLD_W'(HOLD_BASE << sel);
  endfunction

  // Incoming samples gathered into one array
  logic [MAX_CHAN-1:0][SAMPLE_W-1:0] sample_in;
  // Captured samples, one per channel
  logic [MAX_CHAN-1:0][SAMPLE_W-1:0] sample_reg;
  // Upper magnitude bits used for comparison
  logic [MAX_CHAN-1:0][CMP_W-1:0] cmp_reg;
  // Channel reaches the threshold this cycle
  logic [MAX_CHAN-1:0] hit;
  // Remaining hold cycles per channel
  logic [MAX_CHAN-1:0][HOLD_W-1:0] hold_cnt_reg;
  // Held over-range flags
  logic [MAX_CHAN-1:0] flag_reg;
  // Length loaded on every new event
  logic [HOLD_W-1:0] hold_len;

  assign sample_in[0] = i_sample_chan_a;
  assign sample_in[1] = i_sample_chan_b;
  assign sample_in[2] = i_sample_chan_c;
  assign sample_in[3] = i_sample_chan_d;
  assign hold_len = hold_len_fn(i_flag_hold_length_select);

  // Flag pins, each straight from its flag flip-flop
  assign o_flag_out_chan_a = flag_reg[0];
  assign o_flag_out_chan_b = flag_reg[1];
  assign o_flag_out_chan_c = flag_reg[2];
  assign o_flag_out_chan_d = flag_reg[3];

  for (genvar ch = 0; ch < MAX_CHAN; ch++) begin : g_chan
    if (ch < NUM_CHAN) begin : g_used
      // Capture the converted sample on each rising clock edge
      always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
          sample_reg[ch] <= SAMPLE_RST;
        end else begin
          sample_reg[ch] <= sample_in[ch]; // RULE_01
        end
      end

      // Saturating magnitude of the captured sample
      logic [MAG_W-1:0] mag;
      assign mag = mag_fn(sample_reg[ch]); // RULE_04

      // Saturating magnitude, three LSBs dropped
      always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
          cmp_reg[ch] <= CMP_RST;
        end else begin
          cmp_reg[ch] <= mag[MAG_W-1:CMP_LSB]; // RULE_03 RULE_04 RULE_05
        end
      end

      // Shared threshold, gated by the detection enable
      assign hit[ch] = i_overrange_detect_enable
                       && (cmp_reg[ch] >= i_overrange_threshold); // RULE_06 RULE_07 RULE_08

      // Hold counter: reload on every event, count down otherwise
      always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
          hold_cnt_reg[ch] <= HOLD_CNT_RST; // RULE_11
        end else if (!i_overrange_detect_enable) begin
          // Detection off: drop any pending hold
          hold_cnt_reg[ch] <= HOLD_CNT_RST; // RULE_07
        end else if (hit[ch]) begin
          // Restart hold from the latest event
          hold_cnt_reg[ch] <= HOLD_W'(hold_len - 1'b1); // RULE_10 RULE_11
        end else if (hold_cnt_reg[ch] != HOLD_CNT_RST) begin
          // Count the hold down
          hold_cnt_reg[ch] <= HOLD_W'(hold_cnt_reg[ch] - 1'b1); // RULE_10
        end
      end

      // Flag high on the event and while the hold runs
      always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
          flag_reg[ch] <= 1'b0; // RULE_11
        end else if (!i_overrange_detect_enable) begin
          flag_reg[ch] <= 1'b0; // RULE_07
        end else begin
          flag_reg[ch] <= hit[ch] || (hold_cnt_reg[ch] != HOLD_CNT_RST); // RULE_08 RULE_10
        end
      end

      // Cycles since the last event, saturating; checking aid only
      logic [HOLD_W-1:0] age_reg;
      always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
          age_reg <= AGE_RST;
        end else if (!i_overrange_detect_enable) begin
          age_reg <= AGE_RST;
        end else if (hit[ch]) begin
          age_reg <= HOLD_CNT_RST;
        end else if (age_reg != AGE_RST) begin
          age_reg <= HOLD_W'(age_reg + 1'b1);
        end
      end

      // Hold length latched at the last event; checking aid only
      logic [HOLD_W-1:0] len_reg;
      always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
          len_reg <= HOLD_BASE;
        end else if (hit[ch]) begin
          // A running hold keeps the length chosen at its event
          len_reg <= hold_len;
        end
      end

      // Captured sample follows the input one edge later
      sample_capture_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        !$past(i_rst) |-> sample_reg[ch] == $past(sample_in[ch])) // RULE_01
        else $error("sample not captured on clock edge");

      // Negative codes other than the most negative compare on their two's complement magnitude
      sign_to_mag_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (sample_reg[ch][SAMPLE_W-1] && sample_reg[ch] != MIN_CODE)
        |=> cmp_reg[ch] == CMP_W'((~$past(sample_reg[ch]) + 1'b1) >> CMP_LSB)) // RULE_02
        else $error("negative sample magnitude wrong");

      // Positive samples keep their upper bits
      upper_bits_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        !sample_reg[ch][SAMPLE_W-1]
        |=> cmp_reg[ch] == $past(sample_reg[ch][MAG_W-1:CMP_LSB])) // RULE_03
        else $error("positive comparison value wrong");

      // Most negative code reads as full magnitude
      min_code_sat_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        sample_reg[ch] == MIN_CODE |=> cmp_reg[ch] == 8'hFF) // RULE_04
        else $error("most negative code not saturated");

      // Code -2032 gives comparison value 254
      lsb_drop_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        sample_reg[ch] == 12'h0810 |=> cmp_reg[ch] == 8'hFE) // RULE_05
        else $error("dropped bits handled wrong");

      // Reaching the shared threshold raises the flag next cycle
      thresh_hit_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_overrange_detect_enable && cmp_reg[ch] >= i_overrange_threshold)
        |=> flag_reg[ch]) // RULE_06
        else $error("flag missed threshold crossing");

      // Disabled detection holds the flag low
      enable_off_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        !i_overrange_detect_enable |=> !flag_reg[ch] && hold_cnt_reg[ch] == 11'h000) // RULE_07
        else $error("flag active while disabled");

      // Flag rises only after a hit in the previous cycle
      flag_cause_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        $rose(flag_reg[ch]) |-> $past(hit[ch])) // RULE_08
        else $error("flag raised without event");

      // Flag length since the last event matches the select
      hold_length_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        ($stable(i_flag_hold_length_select) && i_overrange_detect_enable
         && $past(i_overrange_detect_enable))
        |-> flag_reg[ch] == (age_reg < len_reg)) // RULE_10
        else $error("flag hold length wrong");

      // A new event restarts the hold count
      hold_restart_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        hit[ch] |=> hold_cnt_reg[ch] == $past(hold_len) - 11'h001) // RULE_11
        else $error("hold not restarted by event");

      // Idle enable never reports a hit
      hit_gated_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        !i_overrange_detect_enable |-> !hit[ch]) // RULE_07
        else $error("hit seen while disabled");

      // Running hold counts down by one each cycle
      hold_countdown_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_overrange_detect_enable && !hit[ch] && hold_cnt_reg[ch] != 11'h000)
        |=> hold_cnt_reg[ch] == $past(hold_cnt_reg[ch]) - 11'h001) // RULE_10
        else $error("hold count did not step down");

      // Flag stays up while a hold is running
      flag_stays_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_overrange_detect_enable && hold_cnt_reg[ch] != 11'h000) |=> flag_reg[ch]) // RULE_10
        else $error("flag dropped during hold");

      // Flag falls once the hold has run out
      flag_fall_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (!hit[ch] && hold_cnt_reg[ch] == 11'h000) |=> !flag_reg[ch]) // RULE_10
        else $error("flag outlived its hold");

      // Hold counter never exceeds the longest length
      hold_bound_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        hold_cnt_reg[ch] < 11'h400) // RULE_10
        else $error("hold count out of range");

      // Full-scale positive code reads as the top comparison value
      max_code_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        sample_reg[ch] == 12'h07FF |=> cmp_reg[ch] == 8'hFF) // RULE_03
        else $error("full-scale code compared wrong");

      // Event pulse stretched to the shortest length
      min_hold_c: cover property (@(posedge i_mclk) disable iff (i_rst)
        hit[ch] && i_flag_hold_length_select == 3'h0 ##1 (flag_reg[ch] && !hit[ch]) [*8]
        ##1 !flag_reg[ch]);

      // Event arriving during an active hold
      retrigger_c: cover property (@(posedge i_mclk) disable iff (i_rst)
        hit[ch] ##3 (hit[ch] && hold_cnt_reg[ch] != 11'h000));

      // Most negative code triggers the flag
      min_code_c: cover property (@(posedge i_mclk) disable iff (i_rst)
        sample_reg[ch] == MIN_CODE ##2 flag_reg[ch]);

      // Event taken with the longest hold selected
      max_hold_c: cover property (@(posedge i_mclk) disable iff (i_rst)
        hit[ch] && i_flag_hold_length_select == 3'h7);
    end else begin : g_absent
      // Channel absent on this variant: pin held low
      // Absent channel never reports a hit
      assign hit[ch] = 1'b0;
      // Absent channel state stays at its reset values
      always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
          sample_reg[ch] <= SAMPLE_RST;
          cmp_reg[ch] <= CMP_RST;
          hold_cnt_reg[ch] <= HOLD_CNT_RST;
          flag_reg[ch] <= 1'b0;
        end else begin
          sample_reg[ch] <= SAMPLE_RST;
          cmp_reg[ch] <= CMP_RST;
          hold_cnt_reg[ch] <= HOLD_CNT_RST;
          flag_reg[ch] <= 1'b0; // RULE_09
        end
      end

      // Pin of an absent channel never rises
      absent_pin_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        !flag_reg[ch]) // RULE_09
        else $error("absent channel flag raised");
    end
  end

endmodule // overrange_detector
`default_nettype wire

//--- logic/ovr_detect_pkg.sv
// Constants shared by the over-range detector
`default_nettype none
package ovr_detect_pkg;
  // Sample and comparison widths
  localparam int SAMPLE_W = 12;
  localparam int MAG_W = 11;
  localparam int CMP_W = 8;
  localparam int CMP_LSB = 3;
  // Hold length select width and counter width
  localparam int SEL_W = 3;
  localparam int HOLD_W = 11;
  // Channel count of the widest variant
  localparam int MAX_CHAN = 4;
  // Most negative code and the magnitude it saturates to
  localparam logic [SAMPLE_W-1:0] MIN_CODE = 12'h0800;
  localparam logic [MAG_W-1:0] MAX_MAG = 11'h07FF;
  // Shortest hold length, doubled per select step
  localparam logic [HOLD_W-1:0] HOLD_BASE = 11'h0008;
  // Reset values
  localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 12'h0000;
  localparam logic [CMP_W-1:0] CMP_RST = 8'h00;
  localparam logic [HOLD_W-1:0] HOLD_CNT_RST = 11'h0000;
  localparam logic [HOLD_W-1:0] AGE_RST = 11'h07FF;
endpackage
`default_nettype wire

//--- sim/gain_step_model.sv
// Downstream gain logic that steps the gain down on each over-range that starts while all flags are low
`timescale 1ns/1ps
`default_nettype none
module gain_step_model (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [3:0] i_flags,
  output logic [15:0] o_gain_steps
);
  // Any flag seen on the previous edge
  logic any_reg;
  // One gain step each time the flags go from all low to any high
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      any_reg <= 1'b0;
      o_gain_steps <= 16'h0000;
    end else begin
      any_reg <= |i_flags;
      if ((|i_flags) && !any_reg) begin
        o_gain_steps <= o_gain_steps + 16'h0001;
      end
    end
  end
endmodule // gain_step_model
`default_nettype wire

//--- sim/overrange_detector_tb.sv
// Self-checking bench for the over-range detector
`timescale 1ns/1ps
`default_nettype none
module overrange_detector_tb;
  import ovr_detect_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic [3:0][SAMPLE_W-1:0] smp = '0; // Samples per channel
  logic [CMP_W-1:0] thr = 8'hE4;
  logic en = 1'b1;
  logic [SEL_W-1:0] sel = 3'h0;
  logic [3:0] flag;
  logic [15:0] steps; // Gain steps seen by the partner
  int bad_count = 0;
  int n_compared = 0;
  // Clock of 4 ns period
  always #2 i_mclk = ~i_mclk;
  overrange_detector #(.NUM_CHAN(4)) dut (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_sample_chan_a(smp[0]), .i_sample_chan_b(smp[1]), .i_sample_chan_c(smp[2]),
    .i_sample_chan_d(smp[3]), .i_overrange_threshold(thr),
    .i_overrange_detect_enable(en), .i_flag_hold_length_select(sel),
    .o_flag_out_chan_a(flag[0]), .o_flag_out_chan_b(flag[1]),
    .o_flag_out_chan_c(flag[2]), .o_flag_out_chan_d(flag[3]));
  gain_step_model partner (.i_mclk(i_mclk), .i_rst(i_rst), .i_flags(flag),
    .o_gain_steps(steps));
  // Compare and report a mismatch
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // One sample on a channel for one cycle, then zero
  task automatic hit(input int ch, input logic [SAMPLE_W-1:0] v);
    @(posedge i_mclk);
    smp[ch] <= v;
    @(posedge i_mclk);
    smp[ch] <= 12'h000;
  endtask
  // Cycles until the flag rises, then cycles it stays high
  task automatic span(input int ch, output int w, output int len);
    w = 0;
    len = 0;
    #1;
    while (flag[ch] !== 1'b1 && w < 8) begin
      @(posedge i_mclk);
      #1;
      w++;
    end
    while (flag[ch] === 1'b1 && len < 2000) begin
      @(posedge i_mclk);
      #1;
      len++;
    end
  endtask
  // Magnitude, saturation and truncation boundaries
  task automatic t_codes();
    logic [11:0] v [6] = '{12'h800, 12'h7FF, 12'h810, 12'h810, 12'h7F0, 12'h7EF};
    logic [7:0] t [6] = '{8'hFF, 8'hFF, 8'hFF, 8'hFE, 8'hFE, 8'hFE};
    logic e [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    int w;
    int len;
    for (int k = 0; k < 6; k++) begin
      thr <= t[k];
      hit(0, v[k]);
      span(0, w, len);
      check("code flag length", e[k] ? 16'h0008 : 16'h0000, 16'(len));
      if (e[k]) check("flag latency", 16'h0002, 16'(w));
    end
  endtask
  // Every hold length select, counted in cycles
  task automatic t_hold();
    int w;
    int len;
    logic [15:0] s0;
    s0 = steps;
    for (int k = 0; k < 8; k++) begin
      sel <= 3'(k);
      hit(0, 12'h800);
      span(0, w, len);
      check("hold length", 16'h0008 << k, 16'(len));
    end
    check("gain steps", s0 + 16'h0008, steps);
    sel <= 3'h0;
  endtask
  // A second event during the hold restarts it
  task automatic t_restart();
    int w;
    int len;
    hit(0, 12'h800);
    repeat (3) @(posedge i_mclk);
    hit(0, 12'h800);
    span(0, w, len);
    check("restarted hold", 16'h000A, 16'(len));
  endtask
  // Each channel flags alone against the shared threshold
  task automatic t_chans();
    for (int k = 0; k < 4; k++) begin
      hit(k, 12'h7FF);
      repeat (2) @(posedge i_mclk);
      #1;
      check("channel flags", 16'(4'h1 << k), 16'(flag));
      repeat (10) @(posedge i_mclk);
    end
  endtask
  // Detection off, then enable dropped during a hold
  task automatic t_enable();
    int w;
    int len;
    en <= 1'b0;
    hit(0, 12'h800);
    span(0, w, len);
    check("flag while disabled", 16'h0000, 16'(len));
    en <= 1'b1;
    hit(0, 12'h800);
    repeat (3) @(posedge i_mclk);
    en <= 1'b0;
    @(posedge i_mclk);
    #1;
    check("flag after disable", 16'h0000, 16'(flag));
    en <= 1'b1;
  endtask
  // Reset during a hold clears the flag at once
  task automatic t_reset();
    hit(0, 12'h800);
    repeat (3) @(posedge i_mclk);
    #1;
    i_rst = 1'b1;
    #1;
    check("flag in reset", 16'h0000, 16'(flag));
    @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_mclk);
    #1;
    check("flag after reset", 16'h0000, 16'(flag));
  endtask
  // Verdict and end of run
  task automatic conclude();
    if (bad_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    t_codes();
    t_hold();
    t_restart();
    t_chans();
    t_enable();
    t_reset();
    conclude();
  end
  // Watchdog, well beyond the expected run
  initial begin
    #40000;
    bad_count++;
    conclude();
  end
endmodule // overrange_detector_tb
`default_nettype wire
